// [hw/crw_pkg.sv]
// Constants and types of the clock, reset and watchdog unit.
// Assumes one 20 MHz reference clock drives all of the unit.
package crw_pkg;

  // Reference clock and derived period
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

  // Least low time on the reset pin that counts as a reset
  localparam int unsigned SPIKE_NS     = 100;
  localparam int unsigned SPIKE_CYC_RAW =
    (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SPIKE_CYC_I  =
    (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;
  localparam logic [3:0]  SPIKE_CYC    = SPIKE_CYC_I[3:0];

  // Start-up interval on the RC oscillator
  localparam logic [10:0] STARTUP_CYC  = 11'h400;
  localparam logic [10:0] STARTUP_LAST = STARTUP_CYC - 11'h001;

  // External clock counts as valid if it toggled within this window
  localparam logic [3:0]  EXT_WIN      = 4'h8;

  // Gate-off cycles around a clock source change
  localparam logic [10:0] GAP_LAST     = 11'h001;

  // System reset is held this many cycles plus one after the last source
  localparam logic [4:0]  RST_STRETCH  = 5'h10;

  // Default watchdog timeout in cycles
  localparam logic [31:0] WDOG_DEFAULT = 32'h0010_0000;

  // Reset cause bits
  localparam int unsigned CAUSE_SUPPLY = 0;
  localparam int unsigned CAUSE_PIN    = 1;
  localparam int unsigned CAUSE_WDOG   = 2;

  typedef logic [2:0] crw_cause_t;

  typedef enum logic [2:0] {
    ST_START   = 3'h0,
    ST_RC_RUN  = 3'h1,
    ST_TO_EXT  = 3'h2,
    ST_EXT_RUN = 3'h3,
    ST_TO_RC   = 3'h4
  } crw_clk_st_t;

endpackage

// [hw/crw_deglitch.sv]
// Level filter: output follows input after a stable run of DEPTH cycles.
// Assumes rawIn is already synchronous to clock.
`timescale 1ns/100ps
module crw_deglitch #(
  parameter logic [3:0] DEPTH = 4'h2,
  parameter logic       INIT  = 1'b1
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic rawIn,
  output logic      stableOut
);
  logic [3:0] runCnt_q;
  logic [3:0] runCnt_d;
  logic       level_q;
  logic       level_d;

  always_comb begin
    runCnt_d = 4'h0;
    level_d  = level_q;
    if (rawIn != level_q) begin
      if (runCnt_q + 4'h1 >= DEPTH) begin
        level_d = rawIn;
      end else begin
        runCnt_d = runCnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      runCnt_q <= 4'h0;
      level_q  <= INIT;
    end else begin
      runCnt_q <= runCnt_d;
      level_q  <= level_d;
    end
  end

  assign stableOut = level_q;

  chk_single_glitch: assert property (@(posedge clock) disable iff (!rst_n)
    (DEPTH > 4'h1 && rawIn != level_q && runCnt_q == 4'h0)
      |=> level_q == $past(level_q))
    else $error("filter passed a one-cycle glitch");
endmodule

// [hw/crw_top.sv]
// Clock source manager, reset sequencer and watchdog of the device.
// Assumes every input is synchronous to clock; extClkSample is the
// external oscillator seen through an activity sampler.
`timescale 1ns/100ps
module crw_top
  import crw_pkg::*;
#(
  parameter logic [31:0] WDOG_TIMEOUT_CYCLES = 32'h0010_0000
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        digitalSupplyRailOk,
  input  wire logic        extResetLowPin_n,
  input  wire logic        extClkSample,
  input  wire logic        swTimeoutMonitorRefresh,
  output logic             clkSelExt,
  output logic             clkGateEn,
  output logic             extClkValid,
  output logic             sysReset_n,
  output logic             coreHalt,
  output logic             swTimeoutMonitorFired,
  output crw_pkg::crw_cause_t resetCause
);
  import crw_pkg::*;

  logic        supplyOk;
  logic        pinHigh;
  logic        anySource;
  logic        rstEnter;

  logic        extPrev_q;
  logic [3:0]  winCnt_q;
  logic [3:0]  winCnt_d;
  logic        extValid_q;
  logic        extValid_d;

  logic [31:0] wdCnt_q;
  logic [31:0] wdCnt_d;
  logic        wdFire_q;
  logic        wdFire_d;

  logic [4:0]  stretch_q;
  logic [4:0]  stretch_d;
  logic        rstN_q;
  logic        rstN_d;
  crw_cause_t  cause_q;
  crw_cause_t  cause_d;

  crw_clk_st_t state_q;
  crw_clk_st_t state_d;
  logic [10:0] cnt_q;
  logic [10:0] cnt_d;
  logic        useExt_q;
  logic        useExt_d;
  logic        gateEn_q;
  logic        gateEn_d;
  logic        retry_q;
  logic        retry_d;

  // Supply monitor and reset pin share one filter design
  crw_deglitch #(
    .DEPTH (SPIKE_CYC),
    .INIT  (1'b0)
  ) uSupplyFilt (
    .clock     (clock),
    .rst_n     (rst_n),
    .rawIn     (digitalSupplyRailOk),
    .stableOut (supplyOk)
  );

  crw_deglitch #(
    .DEPTH (SPIKE_CYC),
    .INIT  (1'b1)
  ) uPinFilt (
    .clock     (clock),
    .rst_n     (rst_n),
    .rawIn     (extResetLowPin_n),
    .stableOut (pinHigh)
  );

  // External clock activity window, counted on the reference clock
  always_comb begin
    if (extClkSample != extPrev_q) begin
      winCnt_d = 4'h0;
    end else if (winCnt_q >= EXT_WIN) begin
      winCnt_d = EXT_WIN;
    end else begin
      winCnt_d = winCnt_q + 4'h1;
    end
    extValid_d = (winCnt_d < EXT_WIN);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      extPrev_q  <= 1'b0;
      winCnt_q   <= EXT_WIN;
      extValid_q <= 1'b0;
    end else begin
      extPrev_q  <= extClkSample;
      winCnt_q   <= winCnt_d;
      extValid_q <= extValid_d;
    end
  end

  // Watchdog: free-running while the system is out of reset
  always_comb begin
    wdFire_d = 1'b0;
    if (!rstN_q || swTimeoutMonitorRefresh) begin
      wdCnt_d = 32'h0000_0000;
    end else if (wdCnt_q >= WDOG_TIMEOUT_CYCLES - 32'h0000_0001) begin
      wdCnt_d  = 32'h0000_0000;
      wdFire_d = 1'b1;
    end else begin
      wdCnt_d = wdCnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wdCnt_q  <= 32'h0000_0000;
      wdFire_q <= 1'b0;
    end else begin
      wdCnt_q  <= wdCnt_d;
      wdFire_q <= wdFire_d;
    end
  end

  // Reset sequencer: any source reloads the stretch count
  assign anySource = !supplyOk || !pinHigh || wdFire_q;
  assign rstEnter  = anySource && rstN_q;

  always_comb begin
    stretch_d = stretch_q;
    rstN_d    = rstN_q;
    cause_d   = cause_q;
    if (anySource) begin
      stretch_d = RST_STRETCH;
      rstN_d    = 1'b0;
    end else if (stretch_q != 5'h00) begin
      stretch_d = stretch_q - 5'h01;
    end else begin
      rstN_d = 1'b1;
    end
    if (rstEnter) begin
      cause_d = '0;
    end
    if (anySource) begin
      cause_d[CAUSE_SUPPLY] = cause_d[CAUSE_SUPPLY] | !supplyOk;
      cause_d[CAUSE_PIN]    = cause_d[CAUSE_PIN] | !pinHigh;
      cause_d[CAUSE_WDOG]   = cause_d[CAUSE_WDOG] | wdFire_q;
    end
  end

  // Power-on holds reset until the supply filter reports good
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stretch_q <= RST_STRETCH;
      rstN_q    <= 1'b0;
      cause_q   <= 3'h1;
    end else begin
      stretch_q <= stretch_d;
      rstN_q    <= rstN_d;
      cause_q   <= cause_d;
    end
  end

  // Clock manager: never held by the reset pin, only restarted
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    useExt_d = useExt_q;
    gateEn_d = gateEn_q;
    retry_d  = retry_q;
    case (state_q)
      ST_START: begin
        if (cnt_q == STARTUP_LAST) begin
          cnt_d = 11'h000;
          if (extValid_q) begin
            state_d  = ST_TO_EXT;
            gateEn_d = 1'b0;
          end else begin
            state_d = ST_RC_RUN;
          end
        end else begin
          cnt_d = cnt_q + 11'h001;
        end
      end
      ST_RC_RUN: begin
        useExt_d = 1'b0;
      end
      ST_TO_EXT: begin
        useExt_d = 1'b1;
        if (cnt_q == GAP_LAST) begin
          cnt_d    = 11'h000;
          gateEn_d = 1'b1;
          state_d  = ST_EXT_RUN;
        end else begin
          cnt_d = cnt_q + 11'h001;
        end
      end
      ST_EXT_RUN: begin
        if (!extValid_q) begin
          gateEn_d = 1'b0;
          cnt_d    = 11'h000;
          state_d  = ST_TO_RC;
        end
      end
      ST_TO_RC: begin
        useExt_d = 1'b0;
        if (cnt_q == GAP_LAST) begin
          cnt_d    = 11'h000;
          gateEn_d = 1'b1;
          retry_d  = 1'b0;
          state_d  = retry_q ? ST_START : ST_RC_RUN;
        end else begin
          cnt_d = cnt_q + 11'h001;
        end
      end
      default: begin
        state_d  = ST_START;
        cnt_d    = 11'h000;
        useExt_d = 1'b0;
        gateEn_d = 1'b1;
      end
    endcase
    // A new reset returns to RC, via a gated switch if needed
    if (rstEnter) begin
      cnt_d = 11'h000;
      if (useExt_q || state_q == ST_TO_EXT) begin
        state_d  = ST_TO_RC;
        gateEn_d = 1'b0;
        retry_d  = 1'b1;
      end else begin
        state_d  = ST_START;
        gateEn_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= ST_START;
      cnt_q    <= 11'h000;
      useExt_q <= 1'b0;
      gateEn_q <= 1'b1;
      retry_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      useExt_q <= useExt_d;
      gateEn_q <= gateEn_d;
      retry_q  <= retry_d;
    end
  end

  assign clkSelExt             = useExt_q;
  assign clkGateEn             = gateEn_q;
  assign extClkValid           = extValid_q;
  assign sysReset_n            = rstN_q;
  assign coreHalt              = !pinHigh;
  assign swTimeoutMonitorFired = wdFire_q;
  assign resetCause            = cause_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_start_on_rc: assert property (
    state_q == ST_START |-> !useExt_q)
    else $error("start-up phase not on RC clock");

  chk_startup_switch: assert property (
    (state_q == ST_START && cnt_q == STARTUP_LAST && extValid_q
      && !rstEnter) |=> state_q == ST_TO_EXT && !clkGateEn
      ##1 clkSelExt)
    else $error("no switch to external clock after start-up");

  chk_no_ext_stay: assert property (
    (state_q == ST_START && cnt_q == STARTUP_LAST && !extValid_q
      && !rstEnter) |=> state_q == ST_RC_RUN && !clkSelExt)
    else $error("left RC clock without a valid external clock");

  chk_fail_fallback: assert property (
    (state_q == ST_EXT_RUN && !extValid_q && !rstEnter)
      |=> !clkGateEn ##1 !clkSelExt ##[1:3] clkGateEn)
    else $error("no fallback to RC on external clock loss");

  chk_gate_off_switch: assert property (
    $changed(clkSelExt) |-> !clkGateEn && !$past(clkGateEn))
    else $error("clock select changed with gate open");

  chk_supply_reset: assert property (
    !supplyOk |=> !sysReset_n [*2])
    else $error("supply loss did not hold reset");

  chk_pin_halt: assert property (
    !extResetLowPin_n [*3] |=> coreHalt && !sysReset_n)
    else $error("held reset pin did not halt logic");

  chk_pin_spike: assert property (
    (pinHigh && !extResetLowPin_n ##1 extResetLowPin_n) |=> !coreHalt)
    else $error("reset pin spike was not filtered");

  chk_wdog_reset: assert property (
    swTimeoutMonitorFired |=> !sysReset_n ##1 wdCnt_q == 32'h0000_0000)
    else $error("watchdog expiry did not reset");

  chk_refresh_clear: assert property (
    swTimeoutMonitorRefresh |=> wdCnt_q == 32'h0000_0000)
    else $error("refresh did not clear watchdog count");

  chk_release_good: assert property (
    $rose(sysReset_n) |-> supplyOk && pinHigh && !$past(anySource))
    else $error("reset released with a source active");

  cov_to_ext: cover property (state_q == ST_TO_EXT ##2 clkSelExt);
  cov_fallback: cover property (state_q == ST_EXT_RUN ##1
    state_q == ST_TO_RC);
  cov_wdog: cover property (swTimeoutMonitorFired);
  cov_pin_rst: cover property ($rose(coreHalt));
endmodule

// [testbench/crw_ext_osc.sv]
// Behavioural external oscillator facing the clock manager.
// Assumes the bench starts and stops it through run; free of bench clock.
`timescale 1ns/100ps
module crw_ext_osc #(
  parameter int HALF_NS = 35
) (
  input  wire logic run,
  output logic      extClk
);
  // Off-rate on purpose so the sampler sees real phase drift
  initial begin
    extClk = 1'b0;
    forever begin
      #(HALF_NS);
      // A stopped crystal holds its level, it does not keep toggling
      if (run === 1'b1) begin
        extClk = ~extClk;
      end
    end
  end
endmodule

// [testbench/tb.sv]
// Self-checking bench of the clock, reset and watchdog unit.
// Assumes the unit's own assertions sit in its files; short watchdog.
`timescale 1ns/100ps
module tb;
  localparam int SEL  = 0;
  localparam int SRST = 3;
  localparam int HALT = 4;
  localparam int FIRE = 5;

  logic                clock;
  logic                rst_n;
  logic                supplyOk;
  logic                pin_n;
  logic                refresh;
  logic                oscRun;
  logic                extClk;
  logic                clkSelExt;
  logic                clkGateEn;
  logic                extClkValid;
  logic                sysReset_n;
  logic                coreHalt;
  logic                fired;
  crw_pkg::crw_cause_t resetCause;
  logic [5:0]          outs;
  int                  n_mismatch;
  int                  checked;
  int                  cyc;

  assign outs = {fired, coreHalt, sysReset_n, extClkValid, clkGateEn,
                 clkSelExt};

  crw_ext_osc #(.HALF_NS(35)) osc (.run(oscRun), .extClk(extClk));

  crw_top #(.WDOG_TIMEOUT_CYCLES(32'h0000_0040)) dut (
    .clock                  (clock),
    .rst_n                  (rst_n),
    .digitalSupplyRailOk    (supplyOk),
    .extResetLowPin_n       (pin_n),
    .extClkSample           (extClk),
    .swTimeoutMonitorRefresh(refresh),
    .clkSelExt              (clkSelExt),
    .clkGateEn              (clkGateEn),
    .extClkValid            (extClkValid),
    .sysReset_n             (sysReset_n),
    .coreHalt               (coreHalt),
    .swTimeoutMonitorFired  (fired),
    .resetCause             (resetCause)
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic wrap_up;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 3900 cycles the sequence needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 9000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic inRange(input int n, input int lo, input int hi);
    chk({7'h00, (n >= lo && n <= hi)}, 8'h01);
  endtask

  task automatic waitFor(input int idx, input logic lvl, input int maxCyc,
                         output int n);
    n = 0;
    while (outs[idx] !== lvl && n < maxCyc) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic powerOn;
    int n;
    @(posedge clock);
    rst_n <= 1'b0;
    cycles(3);
    chk({7'h00, clkSelExt}, 8'h00);
    chk({5'h00, resetCause}, 8'h01);
    @(posedge clock);
    rst_n <= 1'b1;
    waitFor(SRST, 1'b1, 40, n);
    inRange(n, 10, 39);
    waitFor(SEL, 1'b1, 1100, n);
    inRange(n, 980, 1040);
    // Gate reopens one edge after the select moves
    cycles(1);
    chk({6'h00, extClkValid, clkGateEn}, 8'h03);
  endtask

  task automatic clockLoss;
    int n;
    @(posedge clock);
    oscRun <= 1'b0;
    waitFor(SEL, 1'b0, 30, n);
    inRange(n, 8, 29);
    cycles(3);
    chk({6'h00, extClkValid, clkSelExt}, 8'h00);
    chk({7'h00, clkGateEn}, 8'h01);
  endtask

  task automatic watchdog;
    int n;
    int seen;
    seen = 0;
    for (int r = 0; r < 20; r++) begin
      @(posedge clock);
      refresh <= 1'b1;
      @(posedge clock);
      refresh <= 1'b0;
      repeat (30) begin
        @(posedge clock);
        #1;
        seen += (fired === 1'b1);
      end
    end
    chk(8'(seen), 8'h00);
    waitFor(FIRE, 1'b1, 90, n);
    inRange(n, 25, 70);
    waitFor(SRST, 1'b0, 3, n);
    inRange(n, 0, 2);
    chk({7'h00, resetCause[2]}, 8'h01);
    waitFor(SRST, 1'b1, 40, n);
    // Firmware back to steady refresh for the later scenarios
    @(posedge clock);
    refresh <= 1'b1;
  endtask

  task automatic pinReset;
    int n;
    @(posedge clock);
    pin_n <= 1'b0;
    @(posedge clock);
    pin_n <= 1'b1;
    cycles(4);
    chk({6'h00, coreHalt, sysReset_n}, 8'h01);
    @(posedge clock);
    pin_n <= 1'b0;
    oscRun <= 1'b1;
    waitFor(HALT, 1'b1, 3, n);
    inRange(n, 1, 2);
    cycles(2);
    chk({6'h00, sysReset_n, resetCause[1]}, 8'h01);
    @(posedge clock);
    pin_n <= 1'b1;
    waitFor(SRST, 1'b1, 40, n);
    chk({6'h00, coreHalt, clkSelExt}, 8'h00);
    waitFor(SEL, 1'b1, 1100, n);
    inRange(n, 900, 1040);
  endtask

  task automatic supplyDrop;
    int n;
    @(posedge clock);
    supplyOk <= 1'b0;
    oscRun <= 1'b0;
    waitFor(SRST, 1'b0, 5, n);
    inRange(n, 1, 4);
    cycles(6);
    chk({6'h00, resetCause[0], clkSelExt}, 8'h02);
    @(posedge clock);
    supplyOk <= 1'b1;
    waitFor(SRST, 1'b1, 40, n);
    inRange(n, 10, 39);
    cycles(1100);
    chk({6'h00, clkSelExt, extClkValid}, 8'h00);
  endtask

  initial begin
    n_mismatch = 0;
    checked = 0;
    cyc = 0;
    rst_n = 1'b0;
    supplyOk = 1'b1;
    pin_n = 1'b1;
    // Held refresh keeps the short watchdog from cutting long start-ups
    refresh = 1'b1;
    oscRun = 1'b1;
    powerOn();
    clockLoss();
    watchdog();
    pinReset();
    supplyDrop();
    wrap_up();
  end
endmodule
